// ==== hw/tdm_params.svh ====
// Constants for the table-driven Moore state machine
`ifndef TDM_PARAMS_SVH
`define TDM_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TDM_NUM_IN 2
`define TDM_NUM_OUT 2
`define TDM_NUM_STATES 4
`define TDM_STATE_W 2
`define TDM_ROWS_PER_STATE 4
`define TDM_NUM_ROWS 16
`define TDM_ROW_W 4

// ----------------------------------------------------------------
// Reset state and output condition count
// ----------------------------------------------------------------
`define TDM_RESET_STATE 2'h0
`define TDM_OUT_CONDITIONS 12

`endif

// ==== hw/tdm_pkg.sv ====
// Types for the table-driven Moore state machine
`include "tdm_params.svh"

package tdm_pkg;

  // ----------------------------------------------------------------
  // Output bit encoding: level and strength
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TDM_LVL_0, TDM_LVL_1, TDM_LVL_U} tdm_level_t;
  typedef enum logic [1:0] {TDM_STR_S, TDM_STR_R, TDM_STR_Z, TDM_STR_U} tdm_strength_t;

  typedef struct packed {
    tdm_level_t level;
    tdm_strength_t strength;
  } tdm_out_bit_t;

  typedef tdm_out_bit_t [`TDM_NUM_OUT-1:0] tdm_out_vec_t;

  // One transition row: care mask, pattern and destination
  typedef struct packed {
    logic [`TDM_NUM_IN-1:0] care;
    logic [`TDM_NUM_IN-1:0] pattern;
    logic [`TDM_STATE_W-1:0] next_state_index;
  } tdm_row_t;

  typedef enum logic [1:0] {TDM_SCAN_IDLE, TDM_SCAN_HIT, TDM_SCAN_MISS} tdm_scan_t;

endpackage

// ==== hw/tdm_row_match.sv ====
// Priority search of one state's transition rows
`timescale 1ns/10ps
`include "tdm_params.svh"

module tdm_row_match
  import tdm_pkg::*;
(
  // Candidate rows for the current state, row 0 first
  input wire tdm_row_t [`TDM_ROWS_PER_STATE-1:0] rows,
  // Present input vector
  input wire logic [`TDM_NUM_IN-1:0] in_vec,
  // Result
  output logic hit,
  output logic [`TDM_STATE_W-1:0] dest
);

  // Don't-care positions are masked before comparison
  function automatic logic row_hit(input tdm_row_t r, input logic [`TDM_NUM_IN-1:0] v);
    row_hit = ((v ^ r.pattern) & r.care) == '0;
  endfunction

  // First listed row wins; every row is checked from the last down, so a hit on row 0 is assigned last
  always_comb begin
    hit = 1'b0;
    dest = '0;
    for (int i = `TDM_ROWS_PER_STATE - 1; i >= 0; i--) begin
      if (row_hit(rows[i], in_vec)) begin
        hit = 1'b1;
        dest = rows[i].next_state_index;
      end
    end
  end

endmodule // tdm_row_match

// ==== hw/tdm_fsm.sv ====
// Table-driven Moore state machine with per-state output vectors
//
// Functional notes
// - Reset and start-up put the machine into the configured initial state, zero by default.
// - States are integer indices from zero and every table destination is one of them.
// - Each state drives one fixed output vector, so out_vec follows only the state.
// - Each state has a list of input patterns with destinations and the first matching one picks the next state.
// - Each output bit is a level of zero, one or unknown with a strength, twelve conditions per bit.
// - The strength of an output bit is strong, resistive, high impedance or undefined.
`timescale 1ns/10ps
`include "tdm_params.svh"

module tdm_fsm
  import tdm_pkg::*;
#(
  parameter logic [`TDM_STATE_W-1:0] RESET_STATE = `TDM_RESET_STATE
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Logic inputs
  input wire logic [`TDM_NUM_IN-1:0] in_vec,
  // Output vector with level and strength per bit, then state index and miss flag
  output tdm_out_vec_t out_vec,
  output logic [`TDM_STATE_W-1:0] state_index,
  output logic no_match
);

  // ----------------------------------------------------------------
  // Transition and output tables
  // ----------------------------------------------------------------
  // Default contents form a two-bit up/down counter, inputs (clear, up)
  function automatic tdm_row_t mk_row(input logic [1:0] c, input logic [1:0] p, input logic [1:0] d);
    mk_row.care = c;
    mk_row.pattern = p;
    mk_row.next_state_index = d;
  endfunction

  function automatic tdm_out_bit_t drive_strong(input logic b);
    drive_strong.level = b ? TDM_LVL_1 : TDM_LVL_0;
    drive_strong.strength = TDM_STR_S;
  endfunction

  // Output vector of the configured initial state, a constant so the async reset loads no logic
  localparam tdm_out_vec_t RESET_OUT = {drive_strong(RESET_STATE[1]), drive_strong(RESET_STATE[0])};

  tdm_row_t [`TDM_NUM_ROWS-1:0] table_rows;
  tdm_out_vec_t [`TDM_NUM_STATES-1:0] state_out;

  // Table is a constant: every destination fits the state index width
  always_comb begin
    for (int s = 0; s < `TDM_NUM_STATES; s++) begin
      table_rows[s*4 + 0] = mk_row(2'h3, 2'h0, 2'((s + 3) % 4));
      table_rows[s*4 + 1] = mk_row(2'h3, 2'h1, 2'((s + 1) % 4));
      table_rows[s*4 + 2] = mk_row(2'h2, 2'h2, 2'h0);
      table_rows[s*4 + 3] = mk_row(2'h0, 2'h0, 2'h0);
      state_out[s][1] = drive_strong(s[1]);
      state_out[s][0] = drive_strong(s[0]);
    end
  end

  // ----------------------------------------------------------------
  // Next-state search
  // ----------------------------------------------------------------
  tdm_row_t [`TDM_ROWS_PER_STATE-1:0] cur_rows;
  logic hit;
  logic [`TDM_STATE_W-1:0] dest;

  // Slice out the current state's rows
  always_comb begin
    for (int r = 0; r < `TDM_ROWS_PER_STATE; r++) begin
      cur_rows[r] = table_rows[{state_index, 2'(r)}];
    end
  end

  tdm_row_match u_match (
    .rows(cur_rows),
    .in_vec(in_vec),
    .hit(hit),
    .dest(dest)
  );

  // ----------------------------------------------------------------
  // State register and registered outputs
  // ----------------------------------------------------------------
  logic [`TDM_STATE_W-1:0] state_d;
  logic [`TDM_STATE_W-1:0] state_q;
  tdm_out_vec_t out_d;
  tdm_out_vec_t out_q;
  logic miss_d;
  logic miss_q;

  // No matching row: hold the state rather than jump somewhere arbitrary
  always_comb begin
    state_d = hit ? dest : state_q;
    out_d = state_out[state_d];
    miss_d = ~hit;
  end

  // Outputs registered with the state so they never see inputs directly
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RESET_STATE;
      out_q <= RESET_OUT;
      miss_q <= 1'b0;
    end else begin
      state_q <= state_d;
      out_q <= out_d;
      miss_q <= miss_d;
    end
  end

  assign state_index = state_q;
  assign out_vec = out_q;
  assign no_match = miss_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_state;
    @(posedge mclk) $rose(reset_n) |-> state_q == RESET_STATE && out_q == RESET_OUT;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state not initial after reset");

  property p_range;
    @(posedge mclk) disable iff (!reset_n) state_q < `TDM_NUM_STATES;
  endproperty
  a_range: assert property (p_range) else $error("state index out of range");

  property p_moore;
    @(posedge mclk) disable iff (!reset_n) ##1 out_q == state_out[state_q];
  endproperty
  a_moore: assert property (p_moore) else $error("output does not match state");

  sequence s_hit;
    hit;
  endsequence
  property p_step;
    @(posedge mclk) disable iff (!reset_n) s_hit |=> state_q == $past(dest);
  endproperty
  a_step: assert property (p_step) else $error("matched destination not loaded");

  property p_level;
    @(posedge mclk) disable iff (!reset_n) ##1 out_q[0].level != 2'h3 && out_q[1].level != 2'h3;
  endproperty
  a_level: assert property (p_level) else $error("illegal output level code");

  property p_strength;
    @(posedge mclk) disable iff (!reset_n) ##1 out_q[0].strength == TDM_STR_S && out_q[1].strength == TDM_STR_S;
  endproperty
  a_strength: assert property (p_strength) else $error("unexpected output strength");

  property p_clear;
    @(posedge mclk) disable iff (!reset_n) in_vec[1] |=> state_q == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear row not taken first");

  property p_first;
    @(posedge mclk) disable iff (!reset_n) (in_vec == 2'h1) ##1 1'b1 |-> state_q == $past(state_q) + 2'h1;
  endproperty
  a_first: assert property (p_first) else $error("count up row not taken");

  property p_hold;
    @(posedge mclk) disable iff (!reset_n) !hit |=> state_q == $past(state_q) && no_match;
  endproperty
  a_hold: assert property (p_hold) else $error("state moved on a miss");

endmodule // tdm_fsm

// ==== dv/tb_table_driven_moore_fsm.sv ====
// Self-checking bench for the table-driven Moore state machine
`timescale 1ns/10ps
`include "tdm_params.svh"

module tb_table_driven_moore_fsm;
  import tdm_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic mclk;
  logic reset_n;
  logic [`TDM_NUM_IN-1:0] in_vec;
  tdm_out_vec_t out_vec;
  logic [`TDM_STATE_W-1:0] state_index;
  logic no_match;
  int fail_count;
  int check_count;
  logic [7:0] lfsr_q;
  logic [1:0] exp_st;
  logic [1:0] cur_in;
  // Walk, both wrap-arounds, then clear from several states
  logic [1:0] corner [24] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0,
                              2'h0, 2'h0, 2'h1, 2'h3, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1, 2'h3};

  tdm_fsm u_dut (.mclk(mclk), .reset_n(reset_n), .in_vec(in_vec), .out_vec(out_vec),
                 .state_index(state_index), .no_match(no_match));

  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  // Clear wins over count direction, counting wraps at four states
  function automatic logic [1:0] nxt(logic [1:0] s, logic [1:0] i);
    if (i[1]) return 2'h0;
    return i[0] ? s + 2'h1 : s - 2'h1;
  endfunction

  function automatic tdm_out_vec_t out_of(logic [1:0] s);
    tdm_out_vec_t v;
    v[1].level = s[1] ? TDM_LVL_1 : TDM_LVL_0;
    v[1].strength = TDM_STR_S;
    v[0].level = s[0] ? TDM_LVL_1 : TDM_LVL_0;
    v[0].strength = TDM_STR_S;
    return v;
  endfunction

  function automatic logic [7:0] lfsr_next(logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction

  // ----------------------------------------------------------------
  // Compare tasks
  // ----------------------------------------------------------------
  task automatic chk_state(input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value state_index expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_out(input tdm_out_vec_t e, input tdm_out_vec_t g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value out_vec expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_flag(input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value no_match expected %h seen %h", e, g);
    end
  endtask

  task automatic check_all();
    chk_state(exp_st, state_index);
    chk_out(out_of(exp_st), out_vec);
    chk_flag(1'b0, no_match);
  endtask

  // Inputs change by NBA, so the edge still samples the old vector
  task automatic step(input logic [1:0] v);
    @(posedge mclk);
    exp_st = nxt(exp_st, cur_in);
    in_vec <= v;
    cur_in = v;
    #1;
    check_all();
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Roughly 300 cycles are needed, so this leaves wide margin
  initial begin
    repeat (2000) @(posedge mclk);
    fail_count++;
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    in_vec = 2'h1;
    cur_in = 2'h1;
    exp_st = 2'h0;
    fail_count = 0;
    check_count = 0;
    lfsr_q = 8'h20;
    repeat (5) @(posedge mclk);
    #1;
    check_all();
    @(posedge mclk);
    reset_n <= 1'b1;
    foreach (corner[k]) step(corner[k]);
    repeat (200) begin
      lfsr_q = lfsr_next(lfsr_q);
      step(lfsr_q[1:0]);
    end
    // Mid-run reset falls by NBA at an edge; the async path clears the state in that same step
    @(posedge mclk);
    reset_n <= 1'b0;
    #1;
    exp_st = 2'h0;
    check_all();
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (50) begin
      lfsr_q = lfsr_next(lfsr_q);
      step(lfsr_q[1:0]);
    end
    end_of_test();
  end
endmodule // tb_table_driven_moore_fsm
